/* File: rxcfd_cfg.svh */
`ifndef RXCFD_CFG_SVH
`define RXCFD_CFG_SVH
// Framing patterns, ten bits, first received bit in bit 9
`define RXCFD_COMMA_POS      10'h0F8
`define RXCFD_COMMA_NEG      10'h304
`define RXCFD_COMMA_MASK     10'h3FC
`define RXCFD_K285_POS       10'h0FA
`define RXCFD_K285_NEG       10'h305
// Channel count and bit widths
`define RXCFD_CHANNELS       4
`define RXCFD_CHAR_BITS      10
// Transition monitor: six characters
`define RXCFD_NO_TRANS_BITS  60
// Multi-byte window and repeat counts
`define RXCFD_MB_SPAN_BITS   50
`define RXCFD_ALT_REPEATS    4
// Low-latency clock stretch limit, bit periods
`define RXCFD_MAX_STRETCH    2
// Re-enable settle time: 2 ms at 10 ns
`define RXCFD_SETTLE_NS      2000000
`define RXCFD_CLK_NS         10
`define RXCFD_SETTLE_CYC     (`RXCFD_SETTLE_NS / `RXCFD_CLK_NS)
// Range monitor relock period in clock cycles
`define RXCFD_RANGE_CHARS    4096
// Status codes
`define RXCFD_ST_DATA        3'h0
`define RXCFD_ST_SPECIAL     3'h1
`define RXCFD_ST_FRAMECHAR   3'h2
`define RXCFD_ST_BIST_OK     3'h4
`define RXCFD_ST_BIST_ERR    3'h5
`define RXCFD_ST_INVALID     3'h7
// Register map, word byte addresses
`define RXCFD_REG_CTRL0      8'h00
`define RXCFD_REG_STATUS     8'h10
`define RXCFD_CTRL_RESET     16'h0000
`endif

/* File: rxcfd_pkg.sv */
package rxcfd_pkg;
  // Framer alignment modes
  typedef enum logic [1:0]
  {
    RXCFD_FM_LOWLAT = 2'h0,
    RXCFD_FM_ALT    = 2'h1,
    RXCFD_FM_MULTI  = 2'h2,
    RXCFD_FM_SPARE  = 2'h3
  } rxcfd_fmode_t;
endpackage : rxcfd_pkg

/* File: rxcfd_framer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rxcfd_cfg.svh"
// One channel: framer plus decoder on one bit per cycle
module rxcfd_framer
  import rxcfd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        bit_en,
  input  wire logic        bit_in,
  input  wire logic        chan_en,
  input  wire logic        frm_en,
  input  wire logic        frm_char,
  input  wire logic [1:0]  frm_mode,
  input  wire logic        dec_n,
  input  wire logic        dec_tbl,
  input  wire logic        bist_en,
  output logic             char_stb,
  output logic [7:0]       char_data,
  output logic [2:0]       char_st,
  output logic             no_trans
);
  typedef struct packed
  {
    logic [9:0] sh;       // Shift register
    logic [3:0] pos;      // Bit position in character
    logic [3:0] hit_pos;  // Position of last candidate
    logic [5:0] gap;      // Bits since last candidate
    logic [2:0] reps;     // Consecutive candidates
    logic [6:0] idle;     // Bits without transition
    logic       last;     // Previous bit
    logic       stb;
    logic [7:0] dat;
    logic [2:0] st;
    logic [8:0] lfsr;     // Self-test generator
  } rxcfd_fr_t;
  rxcfd_fr_t cur_ff;
  rxcfd_fr_t nxt_s;
  logic [9:0] nsh;
  logic       is_comma;
  logic       is_k285;
  logic       hit;
  logic       bound;
  // Candidate detection on the shifted window
  always_comb
  begin
    nsh      = {cur_ff.sh[8:0], bit_in};
    is_comma = ((nsh & `RXCFD_COMMA_MASK) == `RXCFD_COMMA_POS)
             | ((nsh & `RXCFD_COMMA_MASK) == `RXCFD_COMMA_NEG);
    is_k285  = (nsh == `RXCFD_K285_POS) | (nsh == `RXCFD_K285_NEG);
    hit      = frm_char ? is_k285 : is_comma;
    bound    = (cur_ff.pos == 4'd9);
  end
  // Framing, decode and monitor
  always_comb
  begin
    nxt_s     = cur_ff;
    nxt_s.stb = 1'b0;
    if (!chan_en)
    begin
      nxt_s.idle = 7'd0;
    end
    else if (bit_en)
    begin
      nxt_s.sh   = nsh;
      nxt_s.last = bit_in;
      nxt_s.pos  = bound ? 4'd0 : cur_ff.pos + 4'd1;
      // Transition density monitor
      if (bit_in != cur_ff.last)
        nxt_s.idle = 7'd0;
      else if (cur_ff.idle <= 7'(`RXCFD_NO_TRANS_BITS))
        nxt_s.idle = cur_ff.idle + 7'd1;
      if (cur_ff.gap != 6'h3F)
        nxt_s.gap = cur_ff.gap + 6'd1;
      // Boundary update only when enabled
      if (hit && frm_en)
      begin
        case (frm_mode)
          RXCFD_FM_LOWLAT:
          begin
            // Align at once on first detection
            nxt_s.pos = 4'd0;
          end
          RXCFD_FM_ALT:
          begin
            // Need four back-to-back on same phase
            if (nxt_s.pos == cur_ff.hit_pos && cur_ff.gap == 6'd9)
              nxt_s.reps = (cur_ff.reps == 3'd7) ? 3'd7 : cur_ff.reps + 3'd1;
            else
              nxt_s.reps = 3'd1;
            if (nxt_s.reps >= 3'(`RXCFD_ALT_REPEATS))
              nxt_s.pos = 4'd0;
          end
          default:
          begin
            // Two hits within span on same phase; spare code acts alike
            if (nxt_s.pos == cur_ff.hit_pos
                && cur_ff.gap < 6'(`RXCFD_MB_SPAN_BITS))
              nxt_s.pos = 4'd0;
          end
        endcase
        // Phase kept in the frame that follows, so a realign resets it
        nxt_s.hit_pos = nxt_s.pos;
        nxt_s.gap     = 6'd0;
      end
      // Character complete
      if (nxt_s.pos == 4'd0)
      begin
        nxt_s.stb = 1'b1;
        if (!dec_n)
        begin
          // Raw character onto data and two status lines
          nxt_s.dat = nsh[7:0];
          nxt_s.st  = {hit, nsh[9:8]};
        end
        else if (bist_en)
        begin
          // Compare against the local generator
          nxt_s.dat  = cur_ff.lfsr[7:0];
          nxt_s.st   = (nsh[7:0] == cur_ff.lfsr[7:0]) ?
                       `RXCFD_ST_BIST_OK : `RXCFD_ST_BIST_ERR;
          nxt_s.lfsr = {cur_ff.lfsr[7:0], cur_ff.lfsr[8] ^ cur_ff.lfsr[4]};
        end
        else
        begin
          // Decode: low byte kept, special codes flagged
          nxt_s.dat = nsh[7:0];
          if (is_k285)
          begin
            nxt_s.dat = dec_tbl ? 8'hBC : 8'h05;
            nxt_s.st  = `RXCFD_ST_FRAMECHAR;
          end
          else if (nsh == 10'h000 || nsh == 10'h3FF)
            nxt_s.st = `RXCFD_ST_INVALID;
          else if (is_comma)
            nxt_s.st = `RXCFD_ST_SPECIAL;
          else
            nxt_s.st = `RXCFD_ST_DATA;
        end
      end
    end
  end
  // State register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cur_ff      <= '0;
      cur_ff.lfsr <= 9'h1FF;
    end
    else
      cur_ff <= nxt_s;
  end
  assign char_stb  = cur_ff.stb;
  assign char_data = cur_ff.dat;
  assign char_st   = cur_ff.st;
  assign no_trans  = cur_ff.idle > 7'(`RXCFD_NO_TRANS_BITS);
  // Disabled framer never moves the boundary
  frame_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    (bit_en && chan_en && !frm_en && cur_ff.pos != 4'd9)
    |=> cur_ff.pos == $past(cur_ff.pos) + 4'd1)
    else $error("boundary moved while framer off");
  // Low latency aligns on first hit
  lowlat_align_a: assert property (@(posedge mclk) disable iff (!resetn)
    (bit_en && chan_en && frm_en && hit && frm_mode == 2'h0)
    |=> cur_ff.pos == 4'd0 && cur_ff.stb)
    else $error("low latency did not align");
  // Idle flag after sixty flat bits
  trans_mon_a: assert property (@(posedge mclk) disable iff (!resetn)
    (bit_en && chan_en && bit_in == cur_ff.last && cur_ff.idle == 7'd60) |=> no_trans)
    else $error("no transition flag missing");
endmodule : rxcfd_framer
`default_nettype wire

/* File: rxcfd_avs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rxcfd_cfg.svh"
// Avalon-MM slave: one control word per channel, one status word
module rxcfd_avs
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] status_word,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [63:0]      ctrl_words
);
  typedef struct packed
  {
    logic [3:0][15:0] ctrl;  // Per channel control
    logic [31:0]      rdata; // Read data
    logic             done;  // Answer phase
  } rxcfd_avs_t;
  rxcfd_avs_t cur_ff;
  rxcfd_avs_t nxt_s;
  logic [1:0] idx;
  // Decode and one-wait-state answer
  always_comb
  begin
    nxt_s      = cur_ff;
    idx        = avs_address[3:2];
    nxt_s.done = (avs_read | avs_write) & ~cur_ff.done;
    if ((avs_read | avs_write) && !cur_ff.done)
    begin
      nxt_s.rdata = 32'h0000_0000;
      if (avs_address < `RXCFD_REG_STATUS && avs_address[1:0] == 2'b00)
      begin
        nxt_s.rdata = {16'h0000, cur_ff.ctrl[idx]};
        if (avs_write && avs_byteenable[0])
          nxt_s.ctrl[idx][7:0] = avs_writedata[7:0];
        if (avs_write && avs_byteenable[1])
          nxt_s.ctrl[idx][15:8] = avs_writedata[15:8];
      end
      else if (avs_address == `RXCFD_REG_STATUS)
        nxt_s.rdata = status_word;
    end
  end
  // Registers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      cur_ff <= '0;
    else
      cur_ff <= nxt_s;
  end
  assign avs_readdata    = cur_ff.rdata;
  assign avs_waitrequest = ~cur_ff.done;
  assign ctrl_words      = cur_ff.ctrl;
endmodule : rxcfd_avs
`default_nettype wire

/* File: rxcfd_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rxcfd_cfg.svh"
// Behaviour
// - four channels, each with own power enable
// - disabled channel reports link fault constantly
// - out of range, track reference then relock
// - framer searches every bit position
// - select comma or full K28.5 pattern
// - framer disabled keeps boundary unchanged
// - low latency aligns on first detection
// - low latency output within nine characters
// - mode 10 needs two hits within 50 bits
// - mode 01 needs four consecutive hits
// - status 000 data, 001 special
// - bypass passes raw ten-bit character
// - decoder enabled decodes to eight bits
// - table select picks special mapping
// - decoder compares self-test pattern
// - fault after sixty bits without transition
// - fault low while tracking reference
module rxcfd_top
  import rxcfd_pkg::*;
#(
  parameter int unsigned CHANNELS    = `RXCFD_CHANNELS,
  parameter int unsigned RANGE_CHARS = `RXCFD_RANGE_CHARS
)
(
  input  wire logic                mclk,
  input  wire logic                resetn,
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic [CHANNELS-1:0] line_input_primary,
  input  wire logic [CHANNELS-1:0] line_input_secondary,
  input  wire logic [CHANNELS-1:0] line_bit_valid,
  input  wire logic [CHANNELS-1:0] rate_out_of_range,
  output logic [CHANNELS-1:0]      link_fault_indicator_n,
  output logic [CHANNELS-1:0]      char_valid,
  output logic [CHANNELS*8-1:0]    rx_data_bits,
  output logic [CHANNELS*3-1:0]    rx_status_bits,
  output logic [CHANNELS-1:0]      tracking_reference
);
  // Control word per channel:
  // [0] power enable, [1] framer enable, [2] framing char select,
  // [4:3] framer mode, [5] decoder bypass_n, [6] table select,
  // [7] line input select, [8] self-test enable
  logic [63:0]            ctrl;
  logic [CHANNELS-1:0]    stb;
  logic [CHANNELS*8-1:0]  dat;
  logic [CHANNELS*3-1:0]  st;
  logic [CHANNELS-1:0]    flat;
  typedef struct packed
  {
    logic [3:0]       lfi_n;   // Link fault, active low
    logic [3:0]       trk;     // Tracking reference
    logic [3:0][11:0] rng;     // Range relock counter
    logic [3:0]       vld;
    logic [31:0]      rxd;
    logic [11:0]      rxs;
  } rxcfd_top_t;
  rxcfd_top_t cur_ff;
  rxcfd_top_t nxt_s;

  // Register slave
  rxcfd_avs u_avs
  (
    .mclk            (mclk),
    .resetn          (resetn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .status_word     ({16'h0000, cur_ff.trk, flat, cur_ff.lfi_n, cur_ff.vld}),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .ctrl_words      (ctrl)
  );

  // One framer per channel
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_ch
      rxcfd_framer u_fr
      (
        .mclk      (mclk),
        .resetn    (resetn),
        .bit_en    (line_bit_valid[g] & ctrl[16*g] & ~cur_ff.trk[g]),
        .bit_in    (ctrl[16*g+7] ? line_input_secondary[g]
                                 : line_input_primary[g]),
        .chan_en   (ctrl[16*g]),
        .frm_en    (ctrl[16*g+1]),
        .frm_char  (ctrl[16*g+2]),
        .frm_mode  (ctrl[16*g+4 -: 2]),
        .dec_n     (ctrl[16*g+5]),
        .dec_tbl   (ctrl[16*g+6]),
        .bist_en   (ctrl[16*g+8]),
        .char_stb  (stb[g]),
        .char_data (dat[8*g +: 8]),
        .char_st   (st[3*g +: 3]),
        .no_trans  (flat[g])
      );
    end
  endgenerate

  // Fault, range tracking and output register
  always_comb
  begin
    nxt_s = cur_ff;
    for (int c = 0; c < CHANNELS; c++)
    begin
      // Range monitor: track reference for a relock period
      if (!ctrl[16*c])
      begin
        nxt_s.trk[c] = 1'b0;
        nxt_s.rng[c] = 12'd0;
      end
      else if (cur_ff.trk[c])
      begin
        nxt_s.rng[c] = cur_ff.rng[c] + 12'd1;
        if (cur_ff.rng[c] == 12'(RANGE_CHARS - 1))
          nxt_s.trk[c] = 1'b0;
      end
      else if (rate_out_of_range[c])
      begin
        nxt_s.trk[c] = 1'b1;
        nxt_s.rng[c] = 12'd0;
      end
      // Fault low when disabled, tracking or flat
      nxt_s.lfi_n[c] = ctrl[16*c] & ~nxt_s.trk[c] & ~flat[c];
      nxt_s.vld[c]   = stb[c];
      if (stb[c])
      begin
        nxt_s.rxd[8*c +: 8] = dat[8*c +: 8];
        nxt_s.rxs[3*c +: 3] = st[3*c +: 3];
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      cur_ff <= '0;
    else
      cur_ff <= nxt_s;
  end

  assign link_fault_indicator_n = cur_ff.lfi_n;
  assign tracking_reference     = cur_ff.trk;
  assign char_valid             = cur_ff.vld;
  assign rx_data_bits           = cur_ff.rxd;
  assign rx_status_bits         = cur_ff.rxs;

  // Disabled channel shows fault one cycle later
  disabled_fault_a: assert property (@(posedge mclk) disable iff (!resetn)
    !ctrl[0] |=> !link_fault_indicator_n[0])
    else $error("disabled channel without fault");
  // Tracking forces fault low
  track_fault_a: assert property (@(posedge mclk) disable iff (!resetn)
    tracking_reference[0] |-> !link_fault_indicator_n[0])
    else $error("fault high while tracking");
  // Out of range starts tracking next cycle
  range_track_a: assert property (@(posedge mclk) disable iff (!resetn)
    (ctrl[0] && !cur_ff.trk[0] && rate_out_of_range[0]) |=> tracking_reference[0])
    else $error("tracking not started");
  // Output follows framer strobe
  out_follow_a: assert property (@(posedge mclk) disable iff (!resetn)
    stb[0] |=> char_valid[0] && rx_status_bits[2:0] == $past(st[2:0]))
    else $error("character not presented");
  // Power enable gates channel fault clear
  power_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
    link_fault_indicator_n[0] |-> $past(ctrl[0]))
    else $error("fault clear on disabled channel");
endmodule : rxcfd_top
`default_nettype wire

/* File: rxcfd_tx_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Remote serial transmitter: one line bit per clock, first bit MSB
module rxcfd_tx_model
(
  input  wire logic mclk,
  input  wire logic resetn,
  output logic      ser_bit,
  output logic      ser_valid
);
  logic q[$];  // Pending line bits

  // Queue the n low bits of v, most significant first
  task automatic send(input logic [9:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      q.push_back(v[i]);
    end
  endtask : send

  // Bits still waiting on the line
  function automatic int pending();
    return q.size();
  endfunction : pending

  // One bit per reference-locked clock, no drift against the receiver
  // Idle line toggles so no stale bit is held
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ser_bit   <= 1'b0;
      ser_valid <= 1'b0;
    end
    else if (q.size() > 0)
    begin
      ser_bit   <= q.pop_front();
      ser_valid <= 1'b1;
    end
    else
    begin
      ser_bit   <= ~ser_bit;
      ser_valid <= 1'b0;
    end
  end
endmodule : rxcfd_tx_model
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ns
`default_nettype none
// Bench: register bus tasks plus serial traffic on channel 0
module testbench;
  localparam logic [9:0] K = 10'h0FA;  // Framing character, positive
  localparam logic [9:0] D = 10'h2A5;  // Plain data character
  localparam logic [9:0] C = 10'h0F9;  // Comma, not full framing character
  localparam logic [9:0] P = 10'h00A;  // Five-bit filler 01010
  logic        mclk           = 1'b0;
  logic        resetn         = 1'b0;
  logic [7:0]  avs_address    = 8'h00;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [3:0]  rate_bad       = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ser_bit;
  logic        ser_valid;
  logic [3:0]  fault_n;
  logic [3:0]  char_valid;
  logic [3:0]  tracking;
  logic [31:0] rx_data;
  logic [11:0] rx_status;
  logic [7:0]  last_d;
  logic [2:0]  last_s;
  int          err_count  = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  int          other_char = 0;
  int          nk_tab[4]  = '{1, 4, 2, 2};

  rxcfd_top #(.CHANNELS(4), .RANGE_CHARS(16)) DUT
  (
    .mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .line_input_primary({4{ser_bit}}),
    .line_input_secondary({4{~ser_bit}}), .line_bit_valid({4{ser_valid}}),
    .rate_out_of_range(rate_bad), .link_fault_indicator_n(fault_n),
    .char_valid(char_valid), .rx_data_bits(rx_data), .rx_status_bits(rx_status),
    .tracking_reference(tracking)
  );

  rxcfd_tx_model txm (.mclk(mclk), .resetn(resetn), .ser_bit(ser_bit), .ser_valid(ser_valid));

  // Clock at 100 MHz
  always #5 mclk = ~mclk;

  // Capture channel 0 characters, count strays, cut hangs short
  always @(posedge mclk)
  begin
    cyc++;
    if (char_valid[0] === 1'b1)
    begin
      last_d <= rx_data[7:0];
      last_s <= rx_status[2:0];
    end
    if (char_valid[3:1] !== 3'b000)
      other_char++;
    if (cyc > 20000)
    begin
      err_count++;
      stop_test();
    end
  end

  // Counts, verdict and end of run
  task stop_test;
    $display("err_count=%0d n_tests=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // Compare a word or flag
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  // Compare the last character on channel 0
  task chk_char(input logic [7:0] ed, input logic [2:0] es);
    n_tests++;
    if ({last_s, last_d} !== {es, ed})
    begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, {last_s, last_d}, {es, ed});
    end
  endtask : chk_char

  // Bus write, held until waitrequest is sampled low
  task avs_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    avs_write <= 1'b0;
  endtask : avs_wr

  // Bus read, data taken at the answering edge
  task avs_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_read    <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : avs_rd

  // Wait until the line has drained and the last character landed
  task flush;
    while (txm.pending() > 0)
      @(posedge mclk);
    repeat (4) @(posedge mclk);
  endtask : flush

  // Filler, nk framing chars, nd data chars, optional filler
  task frame_run(input logic [9:0] f, input int nk, input int nd, input bit tail);
    txm.send(P, 5);
    repeat (nk) txm.send(f, 10);
    repeat (nd) txm.send(D, 10);
    if (tail)
      txm.send(P, 5);
    flush();
  endtask : frame_run

  // Main sequence
  initial
  begin
    logic [31:0] rd;
    int          i;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk_word({28'h0, fault_n}, 32'h0000_0000);
    avs_rd(8'h00, rd);
    chk_word(rd, 32'h0000_0000);
    avs_wr(8'h20, 32'hFFFF_FFFF);
    avs_rd(8'h20, rd);
    chk_word(rd, 32'h0000_0000);
    // Disabled channel, self-test, table select and multi-byte framing
    avs_wr(8'h0C, 32'hABCD_0150);
    avs_rd(8'h0C, rd);
    chk_word(rd, 32'h0000_0150);
    // Decoder on, vendor table, then alternate table, then bypass
    avs_wr(8'h00, 32'h0000_0067);
    txm.send(K, 10);
    txm.send(K, 10);
    flush();
    chk_char(8'hBC, 3'h2);
    txm.send(D, 10);
    flush();
    chk_char(8'hA5, 3'h0);
    avs_wr(8'h00, 32'h0000_0027);
    txm.send(K, 10);
    flush();
    chk_char(8'h05, 3'h2);
    avs_wr(8'h00, 32'h0000_0007);
    txm.send(K, 10);
    flush();
    chk_char(8'hFA, 3'h4);
    txm.send(D, 10);
    flush();
    chk_char(8'hA5, 3'h2);
    // Comma ignored with full pattern, taken with comma pattern
    frame_run(C, 1, 1, 1'b1);
    chk_char(8'hAA, 3'h0);
    avs_wr(8'h00, 32'h0000_0003);
    frame_run(C, 1, 1, 1'b0);
    chk_char(8'hA5, 3'h2);
    // Each mode: one hit short keeps boundary, full count moves it
    for (int m = 0; m < 4; m++)
    begin
      avs_wr(8'h00, 32'h0000_0007 | (32'(m) << 3));
      frame_run(K, nk_tab[m] - 1, 4, 1'b1);
      chk_char(8'hAA, 3'h0);
      frame_run(K, nk_tab[m], 1, 1'b0);
      chk_char(8'hA5, 3'h2);
    end
    // Framer off: boundary holds through framing characters
    avs_wr(8'h00, 32'h0000_0005);
    frame_run(K, 4, 4, 1'b1);
    chk_char(8'hAA, 3'h0);
    // Seventy bits without a transition
    avs_wr(8'h00, 32'h0000_0007);
    repeat (7) txm.send(10'h000, 10);
    flush();
    avs_rd(8'h10, rd);
    chk_word(rd & 32'h0000_0110, 32'h0000_0100);
    chk_word({31'h0, fault_n[0]}, 32'h0000_0000);
    // Out of range: track the reference with fault shown, then relock
    rate_bad <= 4'h1;
    repeat (3) @(posedge mclk);
    chk_word({31'h0, tracking[0]}, 32'h0000_0001);
    chk_word({31'h0, fault_n[0]}, 32'h0000_0000);
    rate_bad <= 4'h0;
    for (i = 0; i < 60 && tracking[0] !== 1'b0; i++)
      @(posedge mclk);
    chk_word({31'h0, tracking[0]}, 32'h0000_0000);
    // Self-test with multi-byte framing: plain data mismatches generator
    avs_wr(8'h00, 32'h0000_0137);
    txm.send(D, 10);
    flush();
    chk_word({29'h0, last_s}, 32'h0000_0005);
    // Host swaps to the inverted secondary line and reframes
    avs_wr(8'h00, 32'h0000_0087);
    frame_run(K, 1, 1, 1'b0);
    chk_char(8'h5A, 3'h1);
    chk_word({31'h0, fault_n[0]}, 32'h0000_0001);
    // Disabled channels never produced characters; fault held only
    chk_word(32'(other_char), 32'h0000_0000);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
